//--- rtl/rstseq_defs.svh
// Purpose: timing counts and strap layout for the reset sequencer
// Assumes: sys_clk at 40 MHz (25 ns)
// Notes:   definitions only
`ifndef RSTSEQ_DEFS_SVH
`define RSTSEQ_DEFS_SVH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define RSTSEQ_CLK_PERIOD_PS   25000
`define RSTSEQ_IN_MIN_TICKS    32
`define RSTSEQ_SETUP_TICKS     4
`define RSTSEQ_OUT_MIN_TICKS   512
`define RSTSEQ_HS_GAP_TICKS    16
`define RSTSEQ_REDRIVE_TICKS   1
`define RSTSEQ_OFF_MAX_NS      4
`define RSTSEQ_PLL_LOCK_US     100
`define RSTSEQ_PLL_LOCK_CYC    ((`RSTSEQ_PLL_LOCK_US*1000000)/`RSTSEQ_CLK_PERIOD_PS)
// ----------------------------------------------------------------
// strap and counter widths
// ----------------------------------------------------------------
`define RSTSEQ_BOOT_W          3
`define RSTSEQ_DIV_SEL_W       3
`define RSTSEQ_CNT_W           16
`endif

//--- rtl/rstseq_pkg.sv
// Purpose: types for the reset sequencer
// Assumes: rstseq_defs.svh included first
// Notes:   state enum and strap carrier
`include "rstseq_defs.svh"
package rstseq_pkg;
	// captured straps
	typedef struct packed {
		logic [`RSTSEQ_BOOT_W-1:0] boot_src;
		logic                      input_clock_divide_strap;
	} rstseq_strap_t;

	// sequencer states
	typedef enum logic [2:0] {
		ST_POR,
		ST_PLL,
		ST_HARD,
		ST_GAP,
		ST_RUN
	} rstseq_state_t;
endpackage

//--- rtl/rstseq_top.sv
// Purpose: reset initialization sequencer of the processor
// Assumes: pins synchronous to sys_clk; lines active low
// Notes:   host mode sync ticks come from an enable divider; agent mode uses pci_clk_tick
//
// Notes on behaviour
// - driven hard/soft reset held 512 ticks
// - soft negates 16 ticks after hard
// - strap drive released when hard asserts
// - strap redrive at least 1 tick later
// - wait pll lock time before release
// - host mode: divide strap sets sync period
// - clock source picked by host/agent mode
`timescale 1ns/1ps
`include "rstseq_defs.svh"
module rstseq_top #(
	parameter int PLL_LOCK_CYC = `RSTSEQ_PLL_LOCK_CYC
) (
	input  wire logic                      sys_clk,
	input  wire logic                      resetn,
	input  wire logic                      power_on_rst_line_n,
	input  wire logic                      hard_rst_line_n_i,
	input  wire logic                      soft_rst_line_n_i,
	input  wire logic                      host_mode,
	input  wire logic                      pci_clk_tick,
	input  wire logic [`RSTSEQ_BOOT_W-1:0] boot_src_i,
	input  wire logic                      input_clock_divide_strap_i,
	input  wire logic [`RSTSEQ_BOOT_W-1:0] cfg_drive_val,
	input  wire logic                      pll_locked,
	output logic                           hard_rst_line_n_o,
	output logic                           hard_rst_line_oe,
	output logic                           soft_rst_line_n_o,
	output logic                           soft_rst_line_oe,
	output logic [`RSTSEQ_BOOT_W-1:0]      boot_src_o,
	output logic                           cfg_oe,
	output logic                           sync_tick,
	output rstseq_pkg::rstseq_strap_t      strap_q
);
	import rstseq_pkg::*;

	// ------------------------------------------------------------
	// sync clock tick
	// ------------------------------------------------------------
	logic [`RSTSEQ_DIV_SEL_W-1:0] div_cnt_q;   // host divider
	logic                         div_tick;    // host tick
	logic                         tick;        // chosen tick
	logic                         div_sel;     // divide factor

	// host: divide strap chooses 2 or 4 input clocks per tick
	assign div_sel  = strap_q.input_clock_divide_strap;
	assign div_tick = div_sel ? (div_cnt_q == 3'h3)
	                          : (div_cnt_q == 3'h1);
	// agent mode ticks from the pci clock enable
	assign tick = host_mode ? div_tick : pci_clk_tick;

	// divider counter, one enable pulse per sync period
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_q <= 3'h0;
		end else if (div_tick) begin
			div_cnt_q <= 3'h0;
		end else begin
			div_cnt_q <= div_cnt_q + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// input reset qualification
	// ------------------------------------------------------------
	logic [5:0] por_cnt_q;   // por low length
	logic [5:0] ext_cnt_q;   // external reset low length
	logic       por_low;
	logic       ext_low;
	logic       por_step;
	logic       por_ok;
	logic       ext_ok;

	assign por_low  = !power_on_rst_line_n;
	assign ext_low  = (!hard_rst_line_n_i && !hard_rst_line_oe) ||
	                  (!soft_rst_line_n_i && !soft_rst_line_oe);
	// host counts input clocks, agent counts sync ticks
	assign por_step = host_mode ? 1'b1 : pci_clk_tick;
	assign por_ok   = (por_cnt_q >= 6'(`RSTSEQ_IN_MIN_TICKS));
	// short glitches on the hard/soft reset inputs do not start a flow
	assign ext_ok   = (ext_cnt_q >= 6'(`RSTSEQ_IN_MIN_TICKS));

	// count how long por has been low, saturating
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			por_cnt_q <= 6'h0;
		end else if (!por_low) begin
			por_cnt_q <= 6'h0;
		end else if (por_step && !por_ok) begin
			por_cnt_q <= por_cnt_q + 6'h1;
		end
	end

	// count external hard/soft reset low time in ticks
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ext_cnt_q <= 6'h0;
		end else if (!ext_low) begin
			ext_cnt_q <= 6'h0;
		end else if (tick && !ext_ok) begin
			ext_cnt_q <= ext_cnt_q + 6'h1;
		end
	end

	// ------------------------------------------------------------
	// strap setup tracking
	// ------------------------------------------------------------
	rstseq_strap_t strap_now;    // strap pins now
	rstseq_strap_t strap_prev_q; // last sample
	logic [2:0]    stab_cnt_q;   // stable periods seen
	logic          stab_ok;

	assign strap_now = '{boot_src: boot_src_i,
	                     input_clock_divide_strap:
	                     input_clock_divide_strap_i};
	// strap must be steady this long before por release
	assign stab_ok = (stab_cnt_q >= 3'(`RSTSEQ_SETUP_TICKS));

	// watch strap stability in the clock of the mode
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			strap_prev_q <= '0;
			stab_cnt_q   <= 3'h0;
		end else if (por_step) begin
			strap_prev_q <= strap_now;
			if (strap_now != strap_prev_q) begin
				stab_cnt_q <= 3'h0;
			end else if (!stab_ok) begin
				stab_cnt_q <= stab_cnt_q + 3'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	rstseq_state_t             st_q;
	rstseq_state_t             st_d;
	logic [`RSTSEQ_CNT_W-1:0]  cnt_q;    // shared timer
	logic [`RSTSEQ_CNT_W-1:0]  cnt_d;
	logic                      por_rel;  // qualified por release
	logic                      lock_done;
	logic                      hold_done;
	logic                      gap_done;

	assign por_rel   = !por_low && por_ok && stab_ok;
	// lock bound elapsed or pll reports lock early
	assign lock_done = pll_locked ||
	    (cnt_q >= `RSTSEQ_CNT_W'(PLL_LOCK_CYC - 1));
	// one tick past the minimum: the entry edge falls mid-period
	assign hold_done = (cnt_q > `RSTSEQ_CNT_W'(`RSTSEQ_OUT_MIN_TICKS));
	assign gap_done  = (cnt_q > `RSTSEQ_CNT_W'(`RSTSEQ_HS_GAP_TICKS));

	// next state: por, lock, hard hold, gap, run
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		case (st_q)
			ST_POR: begin
				cnt_d = '0;
				if (por_rel) begin
					st_d = ST_PLL;
				end
			end
			ST_PLL: begin
				cnt_d = cnt_q + `RSTSEQ_CNT_W'(1);
				if (lock_done) begin
					st_d  = ST_HARD;
					cnt_d = '0;
				end
			end
			ST_HARD: begin
				// ticks counted while both lines are held
				if (tick) begin
					cnt_d = cnt_q + `RSTSEQ_CNT_W'(1);
				end
				if (hold_done && pll_locked) begin
					st_d  = ST_GAP;
					cnt_d = '0;
				end
			end
			ST_GAP: begin
				if (tick) begin
					cnt_d = cnt_q + `RSTSEQ_CNT_W'(1);
				end
				if (gap_done) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				cnt_d = '0;
				if (ext_ok) begin
					st_d = ST_HARD; // restart the flow
				end
			end
			default: begin
				st_d  = ST_POR;
				cnt_d = '0;
			end
		endcase
		// por dominates every state
		if (por_low) begin
			st_d  = ST_POR;
			cnt_d = '0;
		end
	end

	// state and timer registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_q  <= ST_POR;
			cnt_q <= '0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// ------------------------------------------------------------
	// strap capture and outputs
	// ------------------------------------------------------------
	logic hard_d;     // hard line asserted next
	logic soft_d;     // soft line asserted next
	logic cfg_oe_d;
	logic hard_neg_q; // hard negated one tick ago

	assign hard_d   = (st_d == ST_POR) || (st_d == ST_PLL) ||
	                  (st_d == ST_HARD);
	assign soft_d   = hard_d || (st_d == ST_GAP);
	// drop strap drive at once on hard assertion; the 4 ns bound
	// is met since the enable leaves a flop with no extra gate
	assign cfg_oe_d = !hard_d && hard_neg_q && tick;

	// straps captured from the pins at the qualified por release
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			strap_q <= '0;
		end else if (st_q == ST_POR && por_rel) begin
			strap_q <= strap_now;
		end
	end

	// remember hard negation to delay redrive a full tick
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hard_neg_q <= 1'b0;
		end else if (hard_d) begin
			hard_neg_q <= 1'b0;
		end else if (tick) begin
			hard_neg_q <= 1'b1;
		end
	end

	// registered pin drivers; lines driven low while asserted
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hard_rst_line_n_o <= 1'b0;
			hard_rst_line_oe  <= 1'b1;
			soft_rst_line_n_o <= 1'b0;
			soft_rst_line_oe  <= 1'b1;
			cfg_oe            <= 1'b0;
			boot_src_o        <= '0;
			sync_tick         <= 1'b0;
		end else begin
			hard_rst_line_n_o <= !hard_d;
			hard_rst_line_oe  <= hard_d;
			soft_rst_line_n_o <= !soft_d;
			soft_rst_line_oe  <= soft_d;
			cfg_oe            <= hard_d ? 1'b0 : (cfg_oe | cfg_oe_d);
			boot_src_o        <= cfg_drive_val;
			sync_tick         <= tick;
		end
	end
endmodule

//--- testbench/rstseq_monitor.sv
// Purpose: port checks of the reset sequencer
// Assumes: sync_tick marks one pci sync period
// Notes:   tick counters see the design tick one cycle late
`timescale 1ns/1ps
module rstseq_monitor (
	input wire logic                      sys_clk,
	input wire logic                      resetn,
	input wire logic                      host_mode,
	input wire logic                      pci_clk_tick,
	input wire logic                      pll_locked,
	input wire logic                      hard_rst_line_n_o,
	input wire logic                      soft_rst_line_n_o,
	input wire logic                      cfg_oe,
	input wire logic                      sync_tick,
	input wire rstseq_pkg::rstseq_strap_t strap_q
);
	import rstseq_pkg::*;
	// ------------------------------------------------
	// tick counters
	// ------------------------------------------------
	logic [15:0] hold_q; // ticks with hard low
	logic [15:0] gap_q;  // ticks between hard and soft
	wire  [15:0] tk = {15'h0, sync_tick};
	// counters clear when their window closes
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hold_q <= 16'h0;
			gap_q  <= 16'h0;
		end else begin
			hold_q <= hard_rst_line_n_o ? 16'h0 : hold_q + tk;
			gap_q  <= (soft_rst_line_n_o | !hard_rst_line_n_o) ?
				16'h0 : gap_q + tk;
		end
	end
	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	hold_min_a: assert property ($rose(hard_rst_line_n_o) |->
		hold_q >= 16'h200) else $error("hard reset too short");
	gap_min_a: assert property ($rose(soft_rst_line_n_o) |->
		gap_q >= 16'h10) else $error("soft released too soon");
	strap_off_a: assert property (!hard_rst_line_n_o |-> !cfg_oe)
		else $error("boot pins driven in hard reset");
	redrive_order_a: assert property ($rose(cfg_oe) |->
		$past(hard_rst_line_n_o, 2)) else $error("boot pins driven early");
	redrive_due_a: assert property ($rose(soft_rst_line_n_o) |->
		##[1:8] cfg_oe) else $error("boot pins never driven");
	lock_wait_a: assert property ($rose(hard_rst_line_n_o) |->
		pll_locked) else $error("hard released before lock");
	div_period_a: assert property (host_mode && sync_tick &&
		strap_q.input_clock_divide_strap |=> !sync_tick [*3] ##1
		sync_tick) else $error("host tick period wrong");
	agent_tick_a: assert property (!host_mode && sync_tick |->
		$past(pci_clk_tick)) else $error("agent tick not from pci");
	cover property ($rose(cfg_oe));
	cover property ($fell(hard_rst_line_n_o) && soft_rst_line_n_o);
	cover property (host_mode && $rose(soft_rst_line_n_o));
endmodule

//--- testbench/rstseq_board.sv
// Purpose: board supervisor and strap pulls
// Assumes: open reset lines pulled high
// Notes:   pll lock is slower than the 512 tick hold
`timescale 1ns/1ps
module rstseq_board #(
	parameter int LOCK_DLY = 2500
) (
	input  wire logic                      sys_clk,
	input  wire logic                      por_n,
	input  wire logic                      ext_n,
	input  wire rstseq_pkg::rstseq_strap_t strap_set,
	input  wire logic                      hard_n_o,
	input  wire logic                      hard_oe,
	input  wire logic                      soft_n_o,
	input  wire logic                      soft_oe,
	input  wire logic                      cfg_oe,
	input  wire logic [2:0]                boot_o,
	output logic                           tick,
	output logic                           locked,
	output logic                           hard_pin,
	output logic                           soft_pin,
	output logic                           div_pin,
	output logic [2:0]                     boot_pin
);
	import rstseq_pkg::*;
	logic [1:0]  div_q  = 2'h0;  // pci period of three clocks
	logic [11:0] lock_q = 12'h0; // clocks since por release
	// lock restarts whenever por is low
	always_ff @(posedge sys_clk) begin
		div_q  <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
		lock_q <= !por_n ? 12'h0 : lock_q + {11'h0, !locked};
	end
	assign tick     = (div_q == 2'h0);
	assign locked   = (int'(lock_q) >= LOCK_DLY);
	// pulls hold straps; device wins once it drives
	assign boot_pin = cfg_oe ? boot_o : strap_set.boot_src;
	assign div_pin  = strap_set.input_clock_divide_strap;
	assign hard_pin = (hard_oe ? hard_n_o : 1'b1) & ext_n;
	assign soft_pin = soft_oe ? soft_n_o : 1'b1;
endmodule

//--- testbench/tb_top.sv
// Purpose: self-checking bench of the reset sequencer
// Assumes: board model resolves the pins
// Notes:   agent boot, outside reset, host boot
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
	bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
	end end
module tb_top;
	import rstseq_pkg::*;
	logic          sys_clk = 0, resetn = 0, host_mode = 0;
	logic          por_n = 0, ext_n = 1;
	logic [2:0]    drv = 3'h6; // value driven onto boot pins
	rstseq_strap_t strap_set = 4'h0, strap_q;
	wire           tick, locked, hard_pin, soft_pin, div_pin;
	wire           hard_o, hard_oe, soft_o, soft_oe, cfg_oe, sync_tick;
	wire  [2:0]    boot_pin, boot_o;
	int            bad_count = 0, samples_checked = 0, cyc = 0;
	rstseq_top #(.PLL_LOCK_CYC(4000)) u_rstseq_top (.sys_clk(sys_clk),
		.resetn(resetn), .power_on_rst_line_n(por_n),
		.hard_rst_line_n_i(hard_pin), .soft_rst_line_n_i(soft_pin),
		.host_mode(host_mode), .pci_clk_tick(tick),
		.boot_src_i(boot_pin), .input_clock_divide_strap_i(div_pin),
		.cfg_drive_val(drv), .pll_locked(locked),
		.hard_rst_line_n_o(hard_o), .hard_rst_line_oe(hard_oe),
		.soft_rst_line_n_o(soft_o), .soft_rst_line_oe(soft_oe),
		.boot_src_o(boot_o), .cfg_oe(cfg_oe), .sync_tick(sync_tick),
		.strap_q(strap_q));
	rstseq_board u_rstseq_board (.sys_clk(sys_clk), .por_n(por_n),
		.ext_n(ext_n), .strap_set(strap_set), .hard_n_o(hard_o),
		.hard_oe(hard_oe), .soft_n_o(soft_o), .soft_oe(soft_oe),
		.cfg_oe(cfg_oe), .boot_o(boot_o), .tick(tick), .locked(locked),
		.hard_pin(hard_pin), .soft_pin(soft_pin), .div_pin(div_pin),
		.boot_pin(boot_pin));
	initial forever #12.5 sys_clk = ~sys_clk;
	// hang guard: whole run is near 15000 clocks
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			results();
		end
	end
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// full boot: por held 164 clocks, straps set long before release
	task automatic boot(input logic hm, input rstseq_strap_t s);
		int i;
		int per; // sync period in clocks; board pci tick is 3
		per = hm ? (s.input_clock_divide_strap ? 4 : 2) : 3;
		@(posedge sys_clk);
		host_mode <= hm;
		strap_set <= s;
		por_n     <= 1'b0;
		resetn    <= 1'b0;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (160) @(posedge sys_clk);
		por_n <= 1'b1;
		repeat (3) @(negedge sys_clk);
		`CHK("strap", s, strap_q)
		for (i = 0; i < 6000 && hard_o !== 1'b1; i++) @(negedge sys_clk);
		`CHK("hard up", 1'b1, hard_o)
		`CHK("lock", 1'b1, locked)
		`CHK("soft", 1'b0, soft_o)
		`CHK("early", 1'b0, cfg_oe)
		for (i = 0; i < 200 && soft_o !== 1'b1; i++) @(negedge sys_clk);
		`CHK("soft up", 1'b1, soft_o)
		`CHK("gap", 1'b1, i >= 16 * per)
		for (i = 0; i < 20 && cfg_oe !== 1'b1; i++) @(negedge sys_clk);
		`CHK("boot", drv, boot_pin)
		$display("boot done, host mode %0d", hm);
	endtask
	// outside hard reset: 30 ticks refused, then 40 ticks taken
	task automatic ext_rst;
		int i;
		@(posedge sys_clk);
		ext_n <= 1'b0;
		repeat (90) @(posedge sys_clk);
		ext_n <= 1'b1;
		repeat (60) @(negedge sys_clk);
		`CHK("short", 1'b1, hard_o)
		@(posedge sys_clk);
		ext_n <= 1'b0;
		repeat (120) @(posedge sys_clk);
		ext_n <= 1'b1;
		@(negedge sys_clk);
		`CHK("hard", 1'b0, hard_o)
		`CHK("off", 1'b0, cfg_oe)
		for (i = 0; i < 4000 && soft_o !== 1'b1; i++) @(negedge sys_clk);
		`CHK("again", 1'b1, soft_o)
		`CHK("hard again", 1'b1, hard_o)
		`CHK("redrive", 1'b1, cfg_oe)
		$display("outside reset done");
	endtask
	initial begin
		boot(1'b0, {3'h5, 1'b0});
		ext_rst();
		boot(1'b1, {3'h2, 1'b1});
		boot(1'b1, {3'h3, 1'b0});
		results();
	end
endmodule
bind rstseq_top rstseq_monitor u_rstseq_monitor (.sys_clk(sys_clk),
	.resetn(resetn), .host_mode(host_mode), .pci_clk_tick(pci_clk_tick),
	.pll_locked(pll_locked), .hard_rst_line_n_o(hard_rst_line_n_o),
	.soft_rst_line_n_o(soft_rst_line_n_o), .cfg_oe(cfg_oe),
	.sync_tick(sync_tick), .strap_q(strap_q));
